// >>> src/pmi_nibble_if.sv
// media independent nibble interface, device end, with apb control registers
`timescale 1ns/10ps
`include "pmi_defs.svh"

module pmi_nibble_if (
  // system
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic [31:0]      prdata_out,
  // medium receive side, asynchronous
  input  wire logic        med_link_up_in,
  input  wire logic        med_rx_active_in,
  input  wire logic        med_rx_sig_err_in,
  input  wire logic        med_rx_code_err_in,
  input  wire logic        med_false_carrier_in,
  input  wire logic [3:0]  med_rx_nibble_in,
  // medium transmit side
  output logic [4:0]       med_tx_symbol_out,
  output logic             med_tx_valid_out,
  output logic             med_tx_strobe_out,
  // mac receive pins
  input  wire logic        rx_tristate_request_in,
  output logic             rx_nibble_clock_out,
  output logic [3:0]       rx_nibble_out,
  output logic             rx_valid_flag_out,
  output logic             rx_error_flag_out,
  output logic             rx_drive_en_out,
  // mac transmit pins
  output logic             tx_nibble_clock_out,
  input  wire logic        tx_enable_line_in,
  input  wire logic        tx_error_line_in,
  input  wire logic [3:0]  tx_nibble_in
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers
  pmi_pkg::pmi_med_rx_type med_s1;   // first stage, read by second only
  pmi_pkg::pmi_med_rx_type med_s;    // usable medium inputs
  pmi_pkg::pmi_mac_tx_type tx_s1;    // first stage, read by second only
  pmi_pkg::pmi_mac_tx_type tx_s;     // usable mac transmit inputs
  logic                    tri_s1;   // tristate request, first stage
  logic                    tri_s;    // tristate request, usable
  logic                    link_d;   // delayed copies for edge detection
  logic                    active_d;

  // two flops on every asynchronous input
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      med_s1 <= '0;
      med_s  <= '0;
      tx_s1  <= '0;
      tx_s   <= '0;
      tri_s1 <= 1'b0;
      tri_s  <= 1'b0;
    end else begin
      med_s1 <= '{med_link_up_in, med_rx_active_in, med_rx_sig_err_in,
                  med_rx_code_err_in, med_false_carrier_in, med_rx_nibble_in};
      med_s  <= med_s1;
      tx_s1  <= '{tx_enable_line_in, tx_error_line_in, tx_nibble_in};
      tx_s   <= tx_s1;
      tri_s1 <= rx_tristate_request_in;
      tri_s  <= tri_s1;
    end
  end

  // edge history of the synchronised levels
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      link_d   <= 1'b0;
      active_d <= 1'b0;
    end else begin
      link_d   <= med_s.link_up;
      active_d <= med_s.active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers over apb
  logic [1:0]  ctrl;        // speed and test bit
  logic [15:0] txerr_cnt;   // errored nibbles sent
  logic        speed_100;   // 100 Mb/s mode
  logic        test_code;   // alternative invalid code
  logic        wr_acc;      // write access phase
  logic        rd_hit;      // read address decoded
  logic [31:0] rd_word;     // selected read data

  assign speed_100   = ctrl[`PMI_CTRL_SPEED_BIT];
  assign test_code   = ctrl[`PMI_CTRL_TEST_BIT];
  assign wr_acc      = psel_in & penable_in & pwrite_in;
  // zero wait state slave
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~rd_hit;

  // address decode, also flags unmapped offsets
  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0000_0000;
    if (paddr_in == `PMI_REG_CTRL) begin
      rd_word = {30'h0000_0000, ctrl};
    end else if (paddr_in == `PMI_REG_STATUS) begin
      rd_word[`PMI_STAT_LINK_BIT]  = med_s.link_up;
      rd_word[`PMI_STAT_VALID_BIT] = rx_valid_flag_out;
      rd_word[`PMI_STAT_TXACT_BIT] = med_tx_valid_out;
      rd_word[`PMI_STAT_TRI_BIT]   = tri_s;
      rd_word[`PMI_STAT_SPEED_BIT] = speed_100;
    end else if (paddr_in == `PMI_REG_TXERR_CNT) begin
      rd_word = {16'h0000, txerr_cnt};
    end else begin
      rd_hit  = 1'b0;
    end
  end

  // control write; only the ctrl word is writable
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl <= `PMI_CTRL_RESET;
    end else if (wr_acc && paddr_in == `PMI_REG_CTRL) begin
      ctrl <= pwdata_in[1:0];
    end
  end

  // read data registered at setup so it stands through the access phase
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= rd_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link clock generation
  logic rx_realign;   // restart receive clock phase
  logic rx_rise;      // receive clock rising this cycle
  logic rx_fall;      // receive clock falling this cycle
  logic tx_rise;      // transmit clock rising this cycle

  // per packet at 10M, only at link bring-up at 100M
  assign rx_realign = speed_100 ? (med_s.link_up & ~link_d)
                                : (med_s.active & ~active_d);

  // receive clock divider
  pmi_clkgen u_rx_clk (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .speed_100_in (speed_100),
    .realign_in   (rx_realign),
    .clk_out      (rx_nibble_clock_out),
    .rise_en_out  (rx_rise),
    .fall_en_out  (rx_fall)
  );

  // transmit clock divider never realigns
  pmi_clkgen u_tx_clk (
    .mclk_in      (mclk_in),
    .rst_in       (rst_in),
    .speed_100_in (speed_100),
    .realign_in   (1'b0),
    .clk_out      (tx_nibble_clock_out),
    .rise_en_out  (tx_rise),
    .fall_en_out  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // receive path
  pmi_pkg::pmi_rx_state_type rx_state;       // framing state
  pmi_pkg::pmi_rx_state_type next_rx_state;
  logic                      rx_err_q;       // error before the tristate gate

  // framing; updates on the falling edge so the mac's rising edge sees
  // settled data with half a period of setup and hold
  always_comb begin
    next_rx_state = rx_state;
    case (rx_state)
      pmi_pkg::PMI_RX_IDLE: begin
        if (med_s.active && !med_s.sig_err) begin
          next_rx_state = pmi_pkg::PMI_RX_RECV;
        end
      end
      pmi_pkg::PMI_RX_RECV: begin
        if (!med_s.active) begin
          next_rx_state = pmi_pkg::PMI_RX_IDLE;
        end else if (med_s.sig_err) begin
          next_rx_state = pmi_pkg::PMI_RX_ABORT;
        end
      end
      pmi_pkg::PMI_RX_ABORT: begin
        // hold valid low until the stream ends
        if (!med_s.active) begin
          next_rx_state = pmi_pkg::PMI_RX_IDLE;
        end
      end
      default: begin
        next_rx_state = pmi_pkg::PMI_RX_IDLE;
      end
    endcase
  end

  // state and data only move on receive clock edges
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rx_state          <= pmi_pkg::PMI_RX_IDLE;
      rx_valid_flag_out <= 1'b0;
      rx_nibble_out     <= 4'h0;
    end else if (rx_fall) begin
      rx_state          <= next_rx_state;
      rx_valid_flag_out <= (next_rx_state == pmi_pkg::PMI_RX_RECV);
      rx_nibble_out     <= med_s.nibble;
    end
  end

  // error flag, 100M only: frame errors or false carrier
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rx_err_q <= 1'b0;
    end else if (rx_fall) begin
      rx_err_q <= speed_100 &
                  ((med_s.active & (med_s.code_err | med_s.sig_err)) |
                   (med_s.false_carrier & ~med_s.active));
    end
  end

  // a tristated mac releases the bus and sees no error
  assign rx_error_flag_out = rx_err_q & ~tri_s;
  assign rx_drive_en_out   = ~tri_s;

  ////////////////////////////////////////////////////////////////////////////
  // transmit path
  // 4b/5b data code groups
  function automatic logic [4:0] enc_4b5b(input logic [3:0] nib);
    logic [4:0] code;
    code = 5'h1e;
    case (nib)
      4'h0: code = 5'h1e;
      4'h1: code = 5'h09;
      4'h2: code = 5'h14;
      4'h3: code = 5'h15;
      4'h4: code = 5'h0a;
      4'h5: code = 5'h0b;
      4'h6: code = 5'h0e;
      4'h7: code = 5'h0f;
      4'h8: code = 5'h12;
      4'h9: code = 5'h13;
      4'ha: code = 5'h16;
      4'hb: code = 5'h17;
      4'hc: code = 5'h1a;
      4'hd: code = 5'h1b;
      4'he: code = 5'h1c;
      default: code = 5'h1d;
    endcase
    return code;
  endfunction

  logic [4:0] next_symbol;   // symbol for the sampled nibble

  // error substitution only in 100M; at 10M the nibble passes raw
  always_comb begin
    if (!speed_100) begin
      next_symbol = {1'b0, tx_s.nibble};
    end else if (tx_s.error && test_code) begin
      next_symbol = `PMI_ALT_INVALID;
    end else if (tx_s.error) begin
      next_symbol = `PMI_HALT_CODE;
    end else begin
      next_symbol = enc_4b5b(tx_s.nibble);
    end
  end

  // sample on the transmit clock rising edge, stop when enable drops
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      med_tx_symbol_out <= 5'h00;
      med_tx_valid_out  <= 1'b0;
      med_tx_strobe_out <= 1'b0;
    end else begin
      med_tx_strobe_out <= tx_rise & tx_s.enable;
      if (tx_rise) begin
        med_tx_valid_out  <= tx_s.enable;
        med_tx_symbol_out <= tx_s.enable ? next_symbol : 5'h00;
      end
    end
  end

  // count of nibbles replaced by an invalid symbol
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      txerr_cnt <= 16'h0000;
    end else if (tx_rise && tx_s.enable && tx_s.error && speed_100) begin
      txerr_cnt <= txerr_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_tx_err_sample;
    tx_rise && tx_s.enable && tx_s.error && speed_100;
  endsequence

  sequence s_fast_high;
    tx_nibble_clock_out [*2] ##1 !tx_nibble_clock_out;
  endsequence

  a_rx_err_10m:     assert property (!speed_100 && $past(!speed_100, 2) && !rx_fall
                      |=> !rx_err_q)
    else $error("receive error seen in 10M mode");
  a_rx_err_sync:    assert property ($changed(rx_err_q) |-> $past(rx_fall))
    else $error("receive error moved off the receive clock");
  a_rx_valid_sync:  assert property ($changed(rx_valid_flag_out) |-> $past(rx_fall))
    else $error("valid moved off the receive clock");
  a_tri_gate:       assert property (tri_s |-> !rx_error_flag_out && !rx_drive_en_out)
    else $error("tristated mac still sees receive outputs");
  a_valid_abort:    assert property (rx_fall && rx_valid_flag_out && med_s.sig_err
                      |=> !rx_valid_flag_out)
    else $error("valid held after signal error");
  a_valid_start:    assert property ($rose(rx_valid_flag_out)
                      |-> rx_state == pmi_pkg::PMI_RX_RECV && $past(med_s.active))
    else $error("valid rose without a recovered stream");
  a_halt_sub:       assert property (s_tx_err_sample and !test_code
                      |=> med_tx_symbol_out == `PMI_HALT_CODE)
    else $error("errored nibble not replaced by halt");
  a_alt_code:       assert property (s_tx_err_sample and test_code
                      |=> med_tx_symbol_out == `PMI_ALT_INVALID)
    else $error("test bit set but alternative code not sent");
  a_tx_stop:        assert property (tx_rise && !tx_s.enable
                      |=> !med_tx_valid_out && !med_tx_strobe_out)
    else $error("medium output continued after enable fell");
  a_tx_raw_10m:     assert property (tx_rise && tx_s.enable && !speed_100
                      |=> med_tx_symbol_out == {1'b0, $past(tx_s.nibble)})
    else $error("10M nibble altered by transmit error");
  a_tx_clk_fast:    assert property ($rose(tx_nibble_clock_out) && speed_100
                      && $past(speed_100) |-> s_fast_high)
    else $error("transmit clock high phase wrong at 100M");

endmodule

// >>> src/pmi_defs.svh
// constants for the nibble interface: register map, fields, codes and timing
`ifndef PMI_DEFS_SVH
`define PMI_DEFS_SVH

// register byte offsets on the apb bus
`define PMI_REG_CTRL        12'h000
`define PMI_REG_STATUS      12'h004
`define PMI_REG_TXERR_CNT   12'h008

// control register fields
`define PMI_CTRL_SPEED_BIT  0
`define PMI_CTRL_TEST_BIT   1
`define PMI_CTRL_RESET      2'h0

// status register fields
`define PMI_STAT_LINK_BIT   0
`define PMI_STAT_VALID_BIT  1
`define PMI_STAT_TXACT_BIT  2
`define PMI_STAT_TRI_BIT    3
`define PMI_STAT_SPEED_BIT  4

// substituted code groups for errored transmit nibbles
`define PMI_HALT_CODE       5'h04
`define PMI_ALT_INVALID     5'h01

// timing: system clock and the two link clock rates, in khz
`define PMI_MCLK_KHZ        100000
`define PMI_F10_KHZ         2500
`define PMI_F100_KHZ        25000
`define PMI_HALF_10         (`PMI_MCLK_KHZ / (2 * `PMI_F10_KHZ))
`define PMI_HALF_100        (`PMI_MCLK_KHZ / (2 * `PMI_F100_KHZ))
`define PMI_DIV_W           5

`endif

// >>> src/pmi_pkg.sv
// types shared by the nibble interface design
package pmi_pkg;

  // medium side receive signals after synchronising
  typedef struct packed {
    logic       link_up;
    logic       active;
    logic       sig_err;
    logic       code_err;
    logic       false_carrier;
    logic [3:0] nibble;
  } pmi_med_rx_type;

  // mac side transmit signals after synchronising
  typedef struct packed {
    logic       enable;
    logic       error;
    logic [3:0] nibble;
  } pmi_mac_tx_type;

  // receive framing states
  typedef enum logic [1:0] {
    PMI_RX_IDLE  = 2'b00,
    PMI_RX_RECV  = 2'b01,
    PMI_RX_ABORT = 2'b10
  } pmi_rx_state_type;

endpackage

// >>> src/pmi_clkgen.sv
// divider that makes one link clock and its edge enables from the system clock
`timescale 1ns/10ps
`include "pmi_defs.svh"

module pmi_clkgen (
  // system
  input  wire logic mclk_in,
  input  wire logic rst_in,
  // control
  input  wire logic speed_100_in,
  input  wire logic realign_in,
  // link clock and enables
  output logic      clk_out,
  output logic      rise_en_out,
  output logic      fall_en_out
);

  logic [`PMI_DIV_W-1:0] cnt;   // cycles into the current half period
  logic [`PMI_DIV_W-1:0] last;  // final count of a half period
  logic                  wrap;  // half period ends this cycle

  // half period length follows the selected rate
  assign last = speed_100_in ? `PMI_DIV_W'(`PMI_HALF_100 - 1)
                             : `PMI_DIV_W'(`PMI_HALF_10 - 1);
  // >= so that a switch to the fast rate mid-period cannot stall the count
  assign wrap = (cnt >= last);

  // edge enables line up with the cycle the clock output toggles
  assign rise_en_out = wrap & ~clk_out & ~realign_in;
  assign fall_en_out = wrap & clk_out & ~realign_in;

  // divider; realign restarts a fresh low phase
  always_ff @(posedge mclk_in) begin
    if (rst_in || realign_in) begin
      cnt     <= '0;
      clk_out <= 1'b0;
    end else if (wrap) begin
      cnt     <= '0;
      clk_out <= ~clk_out;
    end else begin
      cnt     <= cnt + `PMI_DIV_W'(1);
    end
  end

endmodule

// >>> dv/pmi_mac_model.sv
// mac side model: launches transmit nibbles after tx clock rises, checks receive nibbles
`timescale 1ns/10ps

module pmi_mac_model (
  // system
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // receive pins from the device
  input  wire logic       rx_clk_in,
  input  wire logic [3:0] rx_nibble_in,
  input  wire logic       rx_valid_in,
  input  wire logic [3:0] exp_nibble_in,
  // transmit pins towards the device
  input  wire logic       tx_clk_in,
  input  wire logic       en_set_in,
  input  wire logic       err_set_in,
  input  wire logic [3:0] nib_set_in,
  output logic            tx_enable_out,
  output logic            tx_error_out,
  output logic [3:0]      tx_nibble_out,
  // capture results
  output int              cap_count_out,
  output int              cap_bad_out
);
  logic tx_prev;  // last seen tx clock level
  logic rx_prev;  // last seen rx clock level

  // edges found by sampling, the clocks are plain levels to this model;
  // one process drives every output, reset keeps pins quiet and counts empty
  always @(posedge mclk_in) begin
    if (rst_in) begin
      tx_prev <= 1'b0;
      rx_prev <= 1'b0;
      tx_enable_out <= 1'b0;
      tx_error_out <= 1'b0;
      tx_nibble_out <= 4'h0;
      cap_count_out <= 0;
      cap_bad_out <= 0;
    end else begin
      tx_prev <= tx_clk_in;
      rx_prev <= rx_clk_in;
      // change only just after a rise, so a full period of setup is given
      if (tx_clk_in && !tx_prev) begin
        tx_enable_out <= en_set_in;
        tx_error_out <= err_set_in;
        tx_nibble_out <= nib_set_in;
      end
      // sample on the rising edge as a real mac would
      if (rx_clk_in && !rx_prev && rx_valid_in) begin
        cap_count_out <= cap_count_out + 1;
        if (rx_nibble_in !== exp_nibble_in) begin
          cap_bad_out <= cap_bad_out + 1;
        end
      end
    end
  end
endmodule

// >>> dv/tb.sv
// self-checking bench for the nibble interface with apb control
`timescale 1ns/10ps
`include "pmi_defs.svh"

module tb;
  logic        mclk_in, rst_in, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rd0;
  logic        link, act, sig_err, code_err, fc, tri_req, err_q;
  logic [3:0]  med_nib, exp_nib, nib_set;
  logic [4:0]  sym;
  logic        sym_valid, strobe, rx_clk, rx_valid, rx_err, rx_en, tx_clk;
  logic        tx_en, tx_er, en_set, err_set;
  logic [3:0]  rx_nib, tx_nib;
  int          failures, tests_run, cap_count, cap_bad, n;

  pmi_nibble_if DUT (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .med_link_up_in(link), .med_rx_active_in(act), .med_rx_sig_err_in(sig_err),
    .med_rx_code_err_in(code_err), .med_false_carrier_in(fc), .med_rx_nibble_in(med_nib),
    .med_tx_symbol_out(sym), .med_tx_valid_out(sym_valid), .med_tx_strobe_out(strobe),
    .rx_tristate_request_in(tri_req), .rx_nibble_clock_out(rx_clk), .rx_nibble_out(rx_nib),
    .rx_valid_flag_out(rx_valid), .rx_error_flag_out(rx_err), .rx_drive_en_out(rx_en),
    .tx_nibble_clock_out(tx_clk), .tx_enable_line_in(tx_en), .tx_error_line_in(tx_er),
    .tx_nibble_in(tx_nib));

  pmi_mac_model u_mac (.mclk_in(mclk_in), .rst_in(rst_in), .rx_clk_in(rx_clk),
    .rx_nibble_in(rx_nib), .rx_valid_in(rx_valid), .exp_nibble_in(exp_nib), .tx_clk_in(tx_clk),
    .en_set_in(en_set), .err_set_in(err_set), .nib_set_in(nib_set),
    .tx_enable_out(tx_en), .tx_error_out(tx_er), .tx_nibble_out(tx_nib),
    .cap_count_out(cap_count), .cap_bad_out(cap_bad));

  // 100 mhz system clock
  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared tasks

  // one compare for every kind of value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // apb transfer: setup, then access held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    @(posedge mclk_in);
    while (pready !== 1'b1) @(posedge mclk_in);
    q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles of one full period of the rx (sel=1) or tx clock
  task automatic period(input logic sel, output int cnt);
    cnt = 0;
    while ((sel ? rx_clk : tx_clk) !== 1'b0) @(posedge mclk_in);
    while ((sel ? rx_clk : tx_clk) !== 1'b1) @(posedge mclk_in);
    while ((sel ? rx_clk : tx_clk) !== 1'b0) begin @(posedge mclk_in); cnt++; end
    while ((sel ? rx_clk : tx_clk) !== 1'b1) begin @(posedge mclk_in); cnt++; end
  endtask

  // hand a nibble to the mac model, let three symbols pass, check the last
  task automatic tx_case(input logic e, input logic [3:0] d, input logic [4:0] exp);
    en_set <= 1'b1;
    err_set <= e;
    nib_set <= d;
    repeat (3) begin
      @(posedge mclk_in);
      while (strobe !== 1'b1) @(posedge mclk_in);
    end
    chk(sym_valid, 1, "tx valid");
    chk(sym, exp, "tx symbol");
  endtask

  // wait for rx valid to reach a level, bounded
  task automatic wait_valid(input logic lvl, input int lim);
    for (int i = 0; i < lim && rx_valid !== lvl; i++) @(posedge mclk_in);
  endtask

  // verdict and end of run
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // watchdog, well beyond the thousand or so cycles the tests need
  initial begin
    #500000;
    failures++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    failures = 0;
    tests_run = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {link, act, sig_err, code_err, fc, tri_req, med_nib} = '0;
    {en_set, err_set, nib_set} = '0;
    exp_nib = 4'hc;
    rst_in = 1'b1;
    repeat (6) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    chk(pready, 1, "pready");
    chk(rx_en, 1, "rx drive");
    chk(rx_valid, 0, "rx valid at reset");
    apb(1'b0, `PMI_REG_CTRL, 0, rd);
    chk(rd, 0, "ctrl reset");
    period(1'b0, n);
    chk(n, 2 * `PMI_HALF_10, "tx period 10M");
    $display("test reset and clocks done");
    // 10M frame, code error present but must not reach the mac
    link <= 1'b1;
    med_nib <= 4'hc;
    code_err <= 1'b1;
    act <= 1'b1;
    wait_valid(1'b1, 4 * `PMI_HALF_10 + 8);
    chk(rx_valid, 1, "valid after start");
    period(1'b1, n);
    chk(n, 2 * `PMI_HALF_10, "rx period 10M");
    chk(rx_err, 0, "rx error at 10M");
    act <= 1'b0;
    code_err <= 1'b0;
    wait_valid(1'b0, 4 * `PMI_HALF_10 + 8);
    chk(rx_valid, 0, "valid after end");
    chk(cap_count != 0, 1, "nibbles taken");
    chk(cap_bad, 0, "nibble bits");
    $display("test rx 10M done");
    // registers
    apb(1'b1, `PMI_REG_CTRL, 32'h0000_0001, rd);
    apb(1'b0, `PMI_REG_STATUS, 0, rd);
    chk(rd[`PMI_STAT_SPEED_BIT], 1, "status speed");
    chk(rd[`PMI_STAT_LINK_BIT], 1, "status link");
    apb(1'b0, 12'h00c, 0, rd);
    chk(err_q, 1, "unmapped error");
    chk(rd, 0, "unmapped read");
    apb(1'b1, `PMI_REG_STATUS, 32'hffff_ffff, rd);
    chk(err_q, 0, "status write no error");
    $display("test registers done");
    // 100M receive errors and tristate gating
    period(1'b0, n);
    chk(n, 2 * `PMI_HALF_100, "tx period 100M");
    period(1'b1, n);
    chk(n, 2 * `PMI_HALF_100, "rx period 100M");
    act <= 1'b1;
    code_err <= 1'b1;
    wait_valid(1'b1, 40);
    repeat (8) @(posedge mclk_in);
    chk(rx_err, 1, "frame error 100M");
    tri_req <= 1'b1;
    repeat (3) @(posedge mclk_in);
    chk(rx_err, 0, "error gated");
    chk(rx_en, 0, "rx released");
    tri_req <= 1'b0;
    sig_err <= 1'b1;
    repeat (12) @(posedge mclk_in);
    chk(rx_valid, 0, "valid drops on signal error");
    {act, code_err, sig_err} <= 3'b000;
    repeat (12) @(posedge mclk_in);
    chk(rx_err, 0, "error clears");
    fc <= 1'b1;
    repeat (12) @(posedge mclk_in);
    chk(rx_err, 1, "false carrier");
    fc <= 1'b0;
    $display("test rx 100M done");
    // transmit substitutions and 10M pass-through
    tx_case(1'b1, 4'h5, `PMI_HALT_CODE);
    apb(1'b1, `PMI_REG_CTRL, 32'h0000_0003, rd);
    tx_case(1'b1, 4'h5, `PMI_ALT_INVALID);
    tx_case(1'b0, 4'h5, 5'h0b);
    apb(1'b1, `PMI_REG_CTRL, 32'h0000_0000, rd);
    apb(1'b0, `PMI_REG_TXERR_CNT, 0, rd0);
    chk(rd0 >= 6, 1, "errored nibbles counted");
    tx_case(1'b1, 4'h9, 5'h09);
    tx_case(1'b0, 4'hb, 5'h0b);
    en_set <= 1'b0;
    repeat (6 * `PMI_HALF_10) @(posedge mclk_in);
    chk({sym_valid, sym}, 6'h00, "tx stopped");
    apb(1'b0, `PMI_REG_TXERR_CNT, 0, rd);
    chk(rd, rd0, "no error count at 10M");
    $display("test tx done");
    final_report;
  end
endmodule
